// [sector_protect_device.sv]
// Device end: command capture, protection state, map and write arbitration.
`timescale 1ns/1ps
module sector_protect_device #(
    parameter int MAP_ERASE_CYCLES =
        sector_protect_pkg::PROTECT_MAP_ERASE_CYCLES
) (
    // System clock and reset
    input  wire logic                                  clk_sys,
    input  wire logic                                  rst_n,
    // Link
    spi_link_if.device                                 link,
    // Array write requests from the memory core
    input  wire logic                                  op_req,
    input  wire logic [sector_protect_pkg::SECTOR_W-1:0] op_sector,
    input  wire logic [sector_protect_pkg::PAGE_W-1:0]   op_page,
    output logic                                       op_granted,
    output logic                                       op_denied,
    // Map programming port
    input  wire logic                                  map_wr_en,
    input  wire logic [sector_protect_pkg::SECTOR_W-1:0] map_wr_addr,
    input  wire logic [7:0]                            map_wr_data,
    output logic                                       map_wr_refused,
    // Map read port
    input  wire logic [sector_protect_pkg::SECTOR_W-1:0] map_rd_addr,
    output logic [7:0]                                 map_rd_data,
    // Status
    output logic                                       status_ready,
    output logic                                       status_protect_on,
    output logic                                       status_wp_asserted
);
    localparam int EW = $clog2(MAP_ERASE_CYCLES + 1);

    // Link-clock domain: command shift register.
    logic [31:0] shift_reg;
    logic [5:0]  bits_reg;
    logic        first_reg;

    // System domain.
    logic          cs_s1_reg;
    logic          cs_s2_reg;
    logic          cs_s3_reg;
    logic          cs_rise;
    logic          cmd_ok;
    logic [7:0]    cmd_op;
    logic          wp_on;
    logic          sw_en_reg;
    logic          busy_reg;
    logic [EW-1:0] erase_cnt_reg;
    logic [7:0]    map_mem [sector_protect_pkg::MAP_BYTES];
    logic          protect_active;
    logic          sector_marked;
    logic          erase_start;
    logic          erase_done;
    logic [7:0]    sel_byte;

    // First edge of a frame is flagged by chip select itself, since the link
    // clock stands still between frames.
    always_ff @(posedge link.sck or posedge link.cs_n or negedge rst_n) begin
        if (!rst_n) begin
            first_reg <= 1'b1;
        end else if (link.cs_n) begin
            first_reg <= 1'b1;
        end else begin
            first_reg <= 1'b0;
        end
    end

    // Shift register and bit count hold after the frame for the system side.
    always_ff @(posedge link.sck or negedge rst_n) begin
        if (!rst_n) begin
            shift_reg <= '0;
            bits_reg  <= '0;
        end else if (first_reg) begin
            shift_reg <= {31'h0, link.mosi};
            bits_reg  <= 6'h01;
        end else begin
            shift_reg <= {shift_reg[30:0], link.mosi};
            if (bits_reg != sector_protect_pkg::BITS_MAX) begin
                bits_reg <= bits_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cs_s1_reg <= 1'b1;
            cs_s2_reg <= 1'b1;
            cs_s3_reg <= 1'b1;
        end else begin
            cs_s1_reg <= link.cs_n;
            cs_s2_reg <= cs_s1_reg;
            cs_s3_reg <= cs_s2_reg;
        end
    end

    // The captured word is quiet from the last link edge on, so it is safe
    // to sample once the synchronised chip-select release arrives.
    assign cs_rise = cs_s2_reg && !cs_s3_reg;
    assign cmd_op  = shift_reg[7:0];
    assign cmd_ok  = cs_rise
                     && (bits_reg == sector_protect_pkg::CMD_BITS_W)
                     && (shift_reg[31:8] == sector_protect_pkg::CMD_PREFIX);

    wp_glitch_filter #(
        .COUNT (sector_protect_pkg::WP_FILTER_CYCLES)
    ) u_wp_filter (
        .clk_sys     (clk_sys),
        .rst_n       (rst_n),
        .wp_n_pin    (link.wp_n),
        .wp_asserted (wp_on)
    );

    // Software enable: set by enable, cleared only by disable while the pin
    // is released; reset models the power cycle.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sw_en_reg <= 1'b0;
        end else if (cmd_ok && cmd_op == sector_protect_pkg::OP_ENABLE) begin
            sw_en_reg <= 1'b1;
        end else if (cmd_ok && cmd_op == sector_protect_pkg::OP_DISABLE
                     && !wp_on) begin
            sw_en_reg <= 1'b0;
        end
    end

    // The pin adds protection on top of the software state only.
    assign protect_active = sw_en_reg || wp_on;

    // Map erase ignores the software state but not the pin.
    assign erase_start = cmd_ok && !busy_reg && !wp_on
                         && cmd_op == sector_protect_pkg::OP_MAP_ERASE;
    assign erase_done  = busy_reg
                         && erase_cnt_reg == EW'(MAP_ERASE_CYCLES - 1);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            busy_reg      <= 1'b0;
            erase_cnt_reg <= '0;
        end else if (erase_start) begin
            busy_reg      <= 1'b1;
            erase_cnt_reg <= '0;
        end else if (erase_done) begin
            busy_reg      <= 1'b0;
            erase_cnt_reg <= '0;
        end else if (busy_reg) begin
            erase_cnt_reg <= erase_cnt_reg + 1'b1;
        end
    end

    // Programming only clears bits, so changing a value needs an erase.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < sector_protect_pkg::MAP_BYTES; i++) begin
                map_mem[i] <= sector_protect_pkg::MAP_SHIPPED;
            end
        end else if (erase_done) begin
            for (int i = 0; i < sector_protect_pkg::MAP_BYTES; i++) begin
                map_mem[i] <= sector_protect_pkg::MAP_ERASED;
            end
        end else if (map_wr_en && !wp_on && !busy_reg) begin
            map_mem[map_wr_addr] <= map_mem[map_wr_addr] & map_wr_data;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            map_wr_refused <= 1'b0;
            map_rd_data    <= '0;
        end else begin
            map_wr_refused <= map_wr_en && (wp_on || busy_reg);
            map_rd_data    <= map_mem[map_rd_addr];
        end
    end

    // Sector 0 is split at page 8 into two parts with two-bit fields; other sectors
    // need every bit set, so stray values leave the sector writable.
    assign sel_byte = map_mem[op_sector];
    always_comb begin
        if (op_sector != sector_protect_pkg::SECTOR_ZERO) begin
            sector_marked = (sel_byte == sector_protect_pkg::MAP_ERASED);
        end else if (op_page < sector_protect_pkg::SUB_0A_PAGES) begin
            sector_marked = &sel_byte[sector_protect_pkg::SUB_0A_MSB:
                                      sector_protect_pkg::SUB_0A_LSB];
        end else begin
            sector_marked = &sel_byte[sector_protect_pkg::SUB_0B_MSB:
                                      sector_protect_pkg::SUB_0B_LSB];
        end
    end

    // A denial means the core must not touch the array at all.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            op_granted <= 1'b0;
            op_denied  <= 1'b0;
        end else begin
            op_granted <= op_req && !busy_reg
                          && !(protect_active && sector_marked);
            op_denied  <= op_req && (busy_reg
                          || (protect_active && sector_marked));
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            status_ready       <= 1'b1;
            status_protect_on  <= 1'b0;
            status_wp_asserted <= 1'b0;
        end else begin
            status_ready       <= !(busy_reg || erase_start);
            status_protect_on  <= protect_active;
            status_wp_asserted <= wp_on;
        end
    end
endmodule

// [sector_protect_pkg.sv]
// Shared constants for the sector write-protection link and its two ends.
// What this block does
// - Asserted write-protect refuses map and protected sectors.
// - Write-protect overrides software enable for sectors only.
// - Asserting write-protect activates protection within delay.
// - Releasing write-protect deactivates unless software enabled.
// - Software enable survives write-protect release; disable clears.
// - Disable command ignored while write-protect asserted.
// - Write-protect input is glitch filtered.
// - Host keeps write-protect released to change map.
// - Map holds 64 bytes, byte n governs sector n.
// - Sectors 1-63: ffh protects, 00h unprotects.
// - Sector 0 bits 7:6 page 0-7, 5:4 rest.
// - Map starts all 00h, nothing protected.
// - Map must be erased before it is reprogrammed.
// - Map erase sequence starts on chip select release.
// - Map erase timed, busy shown until done.
// - Map erase accepted with software protection on or off.
// - Erased map with protection on rejects all writes.
// - Enable sequence takes effect on chip select release.
// - Disable sequence takes effect on chip select release.
// - Reset clears the software protection enable.
// - Protection state visible in status.
package sector_protect_pkg;
    localparam logic [23:0] CMD_PREFIX   = 24'h3d2a7f;
    localparam logic [7:0]  OP_ENABLE    = 8'ha9;
    localparam logic [7:0]  OP_DISABLE   = 8'h9a;
    localparam logic [7:0]  OP_MAP_ERASE = 8'hcf;
    localparam int          CMD_BITS     = 32;
    localparam logic [5:0]  CMD_BITS_W   = 6'h20;
    localparam logic [5:0]  BITS_MAX     = 6'h3f;

    localparam int          MAP_BYTES    = 64;
    localparam int          SECTOR_W     = 6;
    localparam int          PAGE_W       = 7;
    localparam logic [7:0]  MAP_ERASED   = 8'hff;
    localparam logic [7:0]  MAP_SHIPPED  = 8'h00;
    localparam logic [5:0]  SECTOR_ZERO  = 6'h00;
    localparam logic [6:0]  SUB_0A_PAGES = 7'h08;
    localparam int          SUB_0A_MSB   = 7;
    localparam int          SUB_0A_LSB   = 6;
    localparam int          SUB_0B_MSB   = 5;
    localparam int          SUB_0B_LSB   = 4;

    localparam int CLK_SYS_MHZ                = 200;
    localparam int WP_FILTER_NS               = 100;
    localparam int WP_FILTER_CYCLES           = (WP_FILTER_NS * CLK_SYS_MHZ
                                                 + 999) / 1000;
    localparam int PROTECT_ENABLE_DELAY_NS    = 1000;
    localparam int PROTECT_ENABLE_CYCLES      = PROTECT_ENABLE_DELAY_NS
                                                * CLK_SYS_MHZ / 1000;
    localparam int PROTECT_DISABLE_DELAY_NS   = 1000;
    localparam int PROTECT_DISABLE_CYCLES     = PROTECT_DISABLE_DELAY_NS
                                                * CLK_SYS_MHZ / 1000;
    localparam int PROTECT_MAP_ERASE_TIME_US  = 50;
    localparam int PROTECT_MAP_ERASE_CYCLES   = PROTECT_MAP_ERASE_TIME_US
                                                * CLK_SYS_MHZ;

    localparam logic [1:0] HOST_HALF_CYCLES = 2'h3;
endpackage

// [spi_link_if.sv]
// Serial link between the host and the protection logic.
`timescale 1ns/1ps
interface spi_link_if;
    logic sck;
    logic cs_n;
    logic mosi;
    logic wp_n;

    modport device (
        input sck,
        input cs_n,
        input mosi,
        input wp_n
    );

    modport host (
        output sck,
        output cs_n,
        output mosi,
        output wp_n
    );
endinterface

// [wp_glitch_filter.sv]
// Synchroniser and glitch filter for the active-low write-protect pin.
`timescale 1ns/1ps
module wp_glitch_filter #(
    parameter int COUNT = 20
) (
    // System side
    input  wire logic clk_sys,
    input  wire logic rst_n,
    // Pin and filtered level
    input  wire logic wp_n_pin,
    output logic      wp_asserted
);
    localparam int CW = $clog2(COUNT + 1);

    logic          sync1_reg;
    logic          sync2_reg;
    logic [CW-1:0] cnt_reg;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sync1_reg <= 1'b1;
            sync2_reg <= 1'b1;
        end else begin
            sync1_reg <= wp_n_pin;
            sync2_reg <= sync1_reg;
        end
    end

    // A pulse shorter than COUNT cycles restarts the count and never flips.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg     <= '0;
            wp_asserted <= 1'b0;
        end else if (!sync2_reg == wp_asserted) begin
            cnt_reg <= '0;
        end else if (cnt_reg == CW'(COUNT - 1)) begin
            cnt_reg     <= '0;
            wp_asserted <= !sync2_reg;
        end else begin
            cnt_reg <= cnt_reg + 1'b1;
        end
    end
endmodule

// [sector_protect_host.sv]
// Host end: sends four-byte protection commands and drives write-protect.
`timescale 1ns/1ps
module sector_protect_host (
    // System clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    // Link
    spi_link_if.host        link,
    // Command port
    input  wire logic       cmd_req,
    input  wire logic [7:0] cmd_op,
    input  wire logic       wp_assert,
    output logic            cmd_busy,
    output logic            cmd_done,
    output logic            cmd_refused
);
    typedef enum logic [2:0] {
        IDLE,
        SELECT,
        SHIFT,
        HOLD,
        GAP
    } host_state_t;

    host_state_t state_reg;
    logic [1:0]  div_reg;
    logic        tick;
    logic [5:0]  bit_cnt_reg;
    logic [31:0] word_reg;
    logic        sck_reg;
    logic        cs_n_reg;
    logic        mosi_reg;
    logic        wp_n_reg;
    logic        blocked;

    assign link.sck  = sck_reg;
    assign link.cs_n = cs_n_reg;
    assign link.mosi = mosi_reg;
    assign link.wp_n = wp_n_reg;

    assign tick = (div_reg == sector_protect_pkg::HOST_HALF_CYCLES);
    // Map erase and disable would be dropped by a protected device anyway.
    assign blocked = wp_assert
                     && (cmd_op == sector_protect_pkg::OP_MAP_ERASE
                         || cmd_op == sector_protect_pkg::OP_DISABLE);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            div_reg <= '0;
        end else if (state_reg == IDLE || tick) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_reg + 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wp_n_reg <= 1'b1;
        end else begin
            wp_n_reg <= !wp_assert;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_reg   <= IDLE;
            bit_cnt_reg <= '0;
            word_reg    <= '0;
            sck_reg     <= 1'b0;
            cs_n_reg    <= 1'b1;
            mosi_reg    <= 1'b0;
            cmd_busy    <= 1'b0;
            cmd_done    <= 1'b0;
            cmd_refused <= 1'b0;
        end else begin
            cmd_done    <= 1'b0;
            cmd_refused <= 1'b0;
            unique case (state_reg)
                IDLE: begin
                    if (cmd_req && blocked) begin
                        cmd_refused <= 1'b1;
                    end else if (cmd_req) begin
                        word_reg    <= {sector_protect_pkg::CMD_PREFIX, cmd_op};
                        bit_cnt_reg <= '0;
                        cs_n_reg    <= 1'b0;
                        cmd_busy    <= 1'b1;
                        state_reg   <= SELECT;
                    end
                end
                SELECT: begin
                    if (tick) begin
                        mosi_reg  <= word_reg[31];
                        word_reg  <= {word_reg[30:0], 1'b0};
                        state_reg <= SHIFT;
                    end
                end
                SHIFT: begin
                    if (tick && !sck_reg) begin
                        sck_reg     <= 1'b1;
                        bit_cnt_reg <= bit_cnt_reg + 1'b1;
                    end else if (tick) begin
                        sck_reg <= 1'b0;
                        if (bit_cnt_reg == sector_protect_pkg::CMD_BITS_W) begin
                            state_reg <= HOLD;
                        end else begin
                            mosi_reg <= word_reg[31];
                            word_reg <= {word_reg[30:0], 1'b0};
                        end
                    end
                end
                HOLD: begin
                    if (tick) begin
                        cs_n_reg  <= 1'b1;
                        state_reg <= GAP;
                    end
                end
                GAP: begin
                    if (tick) begin
                        cmd_busy  <= 1'b0;
                        cmd_done  <= 1'b1;
                        mosi_reg  <= 1'b0;
                        state_reg <= IDLE;
                    end
                end
            endcase
        end
    end
endmodule

// [sector_write_protect_logic_assertions.sv]
// Concurrent checks on the protection link and the device status outputs.
`timescale 1ns/1ps
module sector_write_protect_logic_checker #(
    parameter int ERASE_CYCLES = 20
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Link
    input wire logic sck,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic wp_n,
    // Device status
    input wire logic status_ready,
    input wire logic status_protect_on,
    input wire logic status_wp_asserted
);
    logic       sck_q;
    logic [5:0] rise_cnt;
    logic [3:0] cs_hi;
    logic [7:0] busy_len;
    logic [7:0] wp_lo;
    logic [7:0] wp_hi;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    // Counts link clock rises within one frame.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sck_q    <= 1'b0;
            rise_cnt <= 6'h00;
        end else begin
            sck_q <= sck;
            if (cs_n) rise_cnt <= 6'h00;
            else if (sck && !sck_q) rise_cnt <= rise_cnt + 6'h01;
        end
    end

    // Saturating age counters, so a long wait cannot wrap into a false pass.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cs_hi    <= 4'h0;
            busy_len <= 8'h00;
            wp_lo    <= 8'h00;
            wp_hi    <= 8'h00;
        end else begin
            if (!cs_n) cs_hi <= 4'h0;
            else if (cs_hi != 4'hf) cs_hi <= cs_hi + 4'h1;
            if (status_ready) busy_len <= 8'h00;
            else if (busy_len != 8'hff) busy_len <= busy_len + 8'h01;
            if (wp_n) wp_lo <= 8'h00;
            else if (wp_lo != 8'hff) wp_lo <= wp_lo + 8'h01;
            if (!wp_n) wp_hi <= 8'h00;
            else if (wp_hi != 8'hff) wp_hi <= wp_hi + 8'h01;
        end
    end

    a_sck_idle_low: assert property (cs_n |-> !sck)
        else $error("link clock not idle low outside a frame");
    a_mosi_held_high: assert property (sck |-> $stable(mosi))
        else $error("data moved while link clock high");
    a_sck_half_len: assert property ($rose(sck) |-> sck [*4] ##1 !sck)
        else $error("link clock high phase has wrong length");
    a_frame_bit_count: assert property ($rose(cs_n) |-> rise_cnt == 6'h20)
        else $error("frame did not carry 32 bits");
    a_erase_after_cs: assert property ($fell(status_ready) |->
        cs_hi >= 4'h2 && cs_hi <= 4'h8)
        else $error("map erase did not start on select release");
    a_erase_busy_len: assert property ($rose(status_ready) |->
        busy_len >= ERASE_CYCLES && busy_len <= ERASE_CYCLES + 2)
        else $error("map erase busy time wrong");
    a_erase_wp_block: assert property ($fell(status_ready) |->
        !status_wp_asserted)
        else $error("map erase started with write protect asserted");
    a_wp_filter_on: assert property ($rose(status_wp_asserted) |->
        wp_lo >= 8'h14)
        else $error("write protect taken before filter time");
    a_wp_filter_off: assert property ($fell(status_wp_asserted) |->
        wp_hi >= 8'h14)
        else $error("write protect release taken before filter time");
    a_wp_enable_delay: assert property (wp_lo == 8'hc8 |->
        status_protect_on)
        else $error("protection not on within enable delay");

    c_map_erase: cover property ($fell(status_ready));
    c_wp_taken: cover property ($rose(status_wp_asserted));
    c_full_frame: cover property ($rose(cs_n) && rise_cnt == 6'h20);
endmodule

// [sector_write_protect_logic_bench.sv]
// Self-checking bench joining the host and device ends over the link.
`timescale 1ns/1ps
module sector_write_protect_logic_bench;
    localparam int ERASE_CYC = 20;
    logic       clk_sys, rst_n, cmd_req, wp_assert;
    logic       cmd_busy, cmd_done, cmd_refused;
    logic [7:0] cmd_op, map_wr_data, map_rd_data;
    logic       op_req, op_granted, op_denied, map_wr_en, map_wr_refused;
    logic [5:0] op_sector, map_wr_addr, map_rd_addr;
    logic [6:0] op_page;
    logic       status_ready, status_protect_on, status_wp_asserted;
    logic       prot_exp;
    logic [7:0] mmap [64];
    logic [31:0] r;
    integer     seed, err_total, checks_done, i;

    spi_link_if link ();
    sector_protect_host i_sector_protect_host (
        .clk_sys(clk_sys), .rst_n(rst_n), .link(link), .cmd_req(cmd_req),
        .cmd_op(cmd_op), .wp_assert(wp_assert), .cmd_busy(cmd_busy),
        .cmd_done(cmd_done), .cmd_refused(cmd_refused));
    sector_protect_device #(.MAP_ERASE_CYCLES(ERASE_CYC))
        i_sector_protect_device (
        .clk_sys(clk_sys), .rst_n(rst_n), .link(link), .op_req(op_req),
        .op_sector(op_sector), .op_page(op_page), .op_granted(op_granted),
        .op_denied(op_denied), .map_wr_en(map_wr_en),
        .map_wr_addr(map_wr_addr), .map_wr_data(map_wr_data),
        .map_wr_refused(map_wr_refused), .map_rd_addr(map_rd_addr),
        .map_rd_data(map_rd_data), .status_ready(status_ready),
        .status_protect_on(status_protect_on),
        .status_wp_asserted(status_wp_asserted));
    sector_write_protect_logic_checker #(.ERASE_CYCLES(ERASE_CYC))
        i_sector_write_protect_logic_checker (
        .clk_sys(clk_sys), .rst_n(rst_n), .sck(link.sck), .cs_n(link.cs_n),
        .mosi(link.mosi), .wp_n(link.wp_n), .status_ready(status_ready),
        .status_protect_on(status_protect_on),
        .status_wp_asserted(status_wp_asserted));

    always #2.5 clk_sys = ~clk_sys;

    task automatic test_done();
        if (err_total == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic tick();
        @(posedge clk_sys);
        #1;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp,
                       input string what);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic logic exp_deny(input logic [5:0] s,
                                      input logic [6:0] p);
        if (!prot_exp) return 1'b0;
        if (s != 6'h00) return mmap[s] == 8'hff;
        if (p < 7'h08) return mmap[0][7:6] == 2'b11;
        return mmap[0][5:4] == 2'b11;
    endfunction

    // Back to back; the first two hit the sector 0 page split.
    task automatic rand_ops(input int n, input logic busy);
        logic d;
        for (int k = 0; k < n; k++) begin
            r = $random(seed);
            if (k < 2) r = (32'h7 + k) << 6;
            d = busy | exp_deny(r[5:0], r[12:6]);
            op_req = 1'b1;
            op_sector = r[5:0];
            op_page = r[12:6];
            tick();
            chk(op_denied, d, "op_denied");
            chk(op_granted, !d, "op_granted");
        end
        op_req = 1'b0;
    endtask

    task automatic wr_map(input logic [5:0] a, input logic [7:0] d,
                          input logic refuse);
        map_wr_en = 1'b1;
        map_wr_addr = a;
        map_wr_data = d;
        tick();
        map_wr_en = 1'b0;
        chk(map_wr_refused, refuse, "map_wr_refused");
        if (!refuse) mmap[a] = mmap[a] & d;
        tick();
    endtask

    task automatic chk_map();
        for (int k = 0; k < 64; k++) begin
            map_rd_addr = k[5:0];
            tick();
            chk(map_rd_data, mmap[k], "map_rd_data");
        end
    endtask

    task automatic send_cmd(input logic [7:0] op, input logic wp_late);
        int n;
        logic rf;
        n = 0;
        rf = wp_assert && op != sector_protect_pkg::OP_ENABLE;
        cmd_req = 1'b1;
        cmd_op = op;
        tick();
        chk(cmd_busy, !rf, "cmd_busy");
        cmd_req = 1'b0;
        wp_assert = wp_assert | wp_late;
        while (cmd_done !== 1'b1 && cmd_refused !== 1'b1 && n < 400) begin
            tick();
            n++;
        end
        chk(n < 400, 1'b1, "cmd_done");
        chk(cmd_refused, rf, "cmd_refused");
        repeat (4) tick();
    endtask

    task automatic wait_prot(input logic v);
        int n;
        n = 0;
        while (status_protect_on !== v && n < 205) begin
            tick();
            n++;
        end
        chk(status_protect_on, v, "status_protect_on");
    endtask

    initial begin
        #100000;
        err_total++;
        test_done();
    end

    initial begin
        seed = 85425;
        err_total = 0;
        checks_done = 0;
        prot_exp = 1'b0;
        clk_sys = 1'b0;
        rst_n = 1'b0;
        {cmd_req, cmd_op, wp_assert, op_req, op_sector, op_page} = '0;
        {map_wr_en, map_wr_addr, map_wr_data, map_rd_addr} = '0;
        for (i = 0; i < 64; i++) mmap[i] = 8'h00;
        repeat (4) @(posedge clk_sys);
        #1 rst_n = 1'b1;
        tick();
        chk(status_protect_on, 1'b0, "status_protect_on");
        chk(status_ready, 1'b1, "status_ready");
        chk_map();
        rand_ops(16, 1'b0);
        wr_map(6'h03, 8'hff, 1'b0);
        chk_map();
        send_cmd(sector_protect_pkg::OP_ENABLE, 1'b0);
        prot_exp = 1'b1;
        chk(status_protect_on, 1'b1, "status_protect_on");
        rand_ops(16, 1'b0);
        send_cmd(sector_protect_pkg::OP_MAP_ERASE, 1'b0);
        chk(status_ready, 1'b0, "status_ready");
        rand_ops(4, 1'b1);
        wr_map(6'h01, 8'h00, 1'b1);
        repeat (30) tick();
        chk(status_ready, 1'b1, "status_ready");
        for (i = 0; i < 64; i++) mmap[i] = 8'hff;
        chk_map();
        rand_ops(16, 1'b0);
        for (i = 0; i < 64; i++) begin
            r = $random(seed);
            if (i == 0) wr_map(6'h00, {{2{r[0]}}, {2{r[1]}}, r[5:2]}, 1'b0);
            else wr_map(i[5:0], {8{r[0]}}, 1'b0);
        end
        chk_map();
        rand_ops(40, 1'b0);
        send_cmd(sector_protect_pkg::OP_DISABLE, 1'b0);
        prot_exp = 1'b0;
        chk(status_protect_on, 1'b0, "status_protect_on");
        rand_ops(16, 1'b0);
        // A pulse shorter than the filter must leave no trace.
        wp_assert = 1'b1;
        repeat (10) tick();
        wp_assert = 1'b0;
        repeat (40) begin
            tick();
            chk(status_wp_asserted, 1'b0, "status_wp_asserted");
        end
        wp_assert = 1'b1;
        prot_exp = 1'b1;
        wait_prot(1'b1);
        chk(status_wp_asserted, 1'b1, "status_wp_asserted");
        wr_map(6'h02, 8'h00, 1'b1);
        rand_ops(16, 1'b0);
        send_cmd(sector_protect_pkg::OP_MAP_ERASE, 1'b0);
        chk(status_ready, 1'b1, "status_ready");
        wp_assert = 1'b0;
        prot_exp = 1'b0;
        wait_prot(1'b0);
        send_cmd(sector_protect_pkg::OP_MAP_ERASE, 1'b1);
        chk(status_ready, 1'b1, "status_ready");
        wait_prot(1'b1);
        send_cmd(sector_protect_pkg::OP_ENABLE, 1'b0);
        wp_assert = 1'b0;
        repeat (220) tick();
        chk(status_protect_on, 1'b1, "status_protect_on");
        // Write protect raised mid-frame slips past the host's guard.
        send_cmd(sector_protect_pkg::OP_DISABLE, 1'b1);
        wp_assert = 1'b0;
        repeat (220) tick();
        chk(status_protect_on, 1'b1, "status_protect_on");
        send_cmd(sector_protect_pkg::OP_DISABLE, 1'b0);
        chk(status_protect_on, 1'b0, "status_protect_on");
        test_done();
    end
endmodule
